// >>> core/pmac_conv_timer.sv
// Conversion timer marking the end of one sample of the selected channel
`timescale 1ns/100ps
`default_nettype none

module pmac_conv_timer (
  input  wire logic  clk_i,
  input  wire logic  rst_b_i,
  pmac_ctl_if.cnv    ctl
);
  import pmac_pkg::*;

  logic [19:0] cnt;
  logic        run;

  // ========================================================================
  // Load count minus one, pulse done when it reaches zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt           <= 20'h0_0000;
      run           <= 1'b0;
      ctl.conv_done <= 1'b0;
    end else begin
      ctl.conv_done <= 1'b0;
      if (ctl.conv_start) begin
        cnt <= ctl.conv_cycles - 20'h0_0001;
        run <= 1'b1;
      end else if (ctl.clear) begin
        run <= 1'b0;
      end else if (run) begin
        if (cnt == 20'h0_0000) begin
          run           <= 1'b0;
          ctl.conv_done <= 1'b1;
        end else begin
          cnt <= cnt - 20'h0_0001;
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> core/pmac_ctl_if.sv
// Control carrier between the configuration core and its two countdown timers
`timescale 1ns/100ps
`default_nettype none

interface pmac_ctl_if;
  logic        clear;
  logic        delay_start;
  logic [7:0]  delay_code;
  logic        delay_done;
  logic        conv_start;
  logic [19:0] conv_cycles;
  logic        conv_done;

  modport ctl (output clear, delay_start, delay_code, conv_start, conv_cycles,
               input  delay_done, conv_done);
  modport dly (input clear, delay_start, delay_code, output delay_done);
  modport cnv (input clear, conv_start, conv_cycles, output conv_done);
endinterface

`default_nettype wire

// >>> core/pmac_delay_timer.sv
// Startup delay timer counting whole delay steps before the first conversion
`timescale 1ns/100ps
`default_nettype none

module pmac_delay_timer #(
  parameter int STEP_CYCLES = 100000
) (
  input  wire logic  clk_i,
  input  wire logic  rst_b_i,
  pmac_ctl_if.dly    ctl
);
  import pmac_pkg::*;

  localparam int SW = $clog2(STEP_CYCLES + 1);

  logic [SW-1:0] step_cnt;
  logic [7:0]    steps_left;
  logic          run;

  // ========================================================================
  // Step countdown; a new start wins over a clear issued in the same cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      step_cnt       <= '0;
      steps_left     <= 8'h00;
      run            <= 1'b0;
      ctl.delay_done <= 1'b0;
    end else begin
      ctl.delay_done <= 1'b0;
      if (ctl.delay_start) begin
        step_cnt   <= '0;
        steps_left <= ctl.delay_code;
        run        <= 1'b1;
      end else if (ctl.clear) begin
        run <= 1'b0;
      end else if (run) begin
        if (steps_left == 8'h00) begin
          run            <= 1'b0;
          ctl.delay_done <= 1'b1;
        end else if (step_cnt == SW'(STEP_CYCLES - 1)) begin
          step_cnt   <= '0;
          steps_left <= steps_left - 8'h01;
        end else begin
          step_cnt <= step_cnt + SW'(1);
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> core/pmac_map.svh
// Register map, field positions and timing figures of the converter configuration block
`ifndef PMAC_MAP_SVH
`define PMAC_MAP_SVH

// ==========================================================================
// Register pointers
`define PMAC_PTR_DEV_CFG      8'h00
`define PMAC_PTR_CONV_CFG     8'h01

// ==========================================================================
// Device configuration fields
`define PMAC_DEV_RST_BIT      15
`define PMAC_DLY_MSB          13
`define PMAC_DLY_LSB          6
`define PMAC_RANGE_BIT        4
`define PMAC_DEV_CFG_RESET    16'h0000

// ==========================================================================
// Converter configuration fields
`define PMAC_CONV_CFG_RESET   16'hFB68
`define PMAC_MODE_MSB         15
`define PMAC_MODE_LSB         12
`define PMAC_MODE_CONT_BIT    3
`define PMAC_BUSCT_MSB        11
`define PMAC_BUSCT_LSB        9
`define PMAC_SHCT_MSB         8
`define PMAC_SHCT_LSB         6
`define PMAC_TMPCT_MSB        5
`define PMAC_TMPCT_LSB        3
`define PMAC_AVG_MSB          2
`define PMAC_AVG_LSB          0

// ==========================================================================
// Timing figures: clock in MHz, delay step in ms, conversion times in us
`define PMAC_CLK_MHZ          50
`define PMAC_DLY_STEP_MS      2
`define PMAC_CT0_US           50
`define PMAC_CT1_US           84
`define PMAC_CT2_US           150
`define PMAC_CT3_US           280
`define PMAC_CT4_US           540
`define PMAC_CT5_US           1052
`define PMAC_CT6_US           2074
`define PMAC_CT7_US           4120

// ==========================================================================
// Averaging sample counts
`define PMAC_AVG0             11'h001
`define PMAC_AVG1             11'h004
`define PMAC_AVG2             11'h010
`define PMAC_AVG3             11'h040
`define PMAC_AVG4             11'h080
`define PMAC_AVG5             11'h100
`define PMAC_AVG6             11'h200
`define PMAC_AVG7             11'h400

`endif

// >>> core/pmac_pkg.sv
// Types and lookup functions shared by the converter configuration block
`include "pmac_map.svh"

package pmac_pkg;

  // ========================================================================
  // Types
  typedef enum logic [3:0] {
    W_PTR = 4'b0001,
    W_MSB = 4'b0010,
    W_LSB = 4'b0100,
    W_IGN = 4'b1000
  } pmac_wr_state_t;

  typedef enum logic [3:0] {
    S_OFF   = 4'b0001,
    S_DELAY = 4'b0010,
    S_CONV  = 4'b0100,
    S_NEXT  = 4'b1000
  } pmac_seq_state_t;

  // Channel index: 0 bus, 1 shunt, 2 temperature, 3 none
  typedef logic [1:0] pmac_ch_t;
  localparam pmac_ch_t CH_NONE = 2'h3;

  // ========================================================================
  // Conversion time code to microseconds
  function automatic logic [12:0] pmac_conv_us(input logic [2:0] ct);
    case (ct)
      3'h0:    pmac_conv_us = 13'(`PMAC_CT0_US);
      3'h1:    pmac_conv_us = 13'(`PMAC_CT1_US);
      3'h2:    pmac_conv_us = 13'(`PMAC_CT2_US);
      3'h3:    pmac_conv_us = 13'(`PMAC_CT3_US);
      3'h4:    pmac_conv_us = 13'(`PMAC_CT4_US);
      3'h5:    pmac_conv_us = 13'(`PMAC_CT5_US);
      3'h6:    pmac_conv_us = 13'(`PMAC_CT6_US);
      default: pmac_conv_us = 13'(`PMAC_CT7_US);
    endcase
  endfunction

  // Averaging code to sample count
  function automatic logic [10:0] pmac_avg_count(input logic [2:0] code);
    case (code)
      3'h0:    pmac_avg_count = `PMAC_AVG0;
      3'h1:    pmac_avg_count = `PMAC_AVG1;
      3'h2:    pmac_avg_count = `PMAC_AVG2;
      3'h3:    pmac_avg_count = `PMAC_AVG3;
      3'h4:    pmac_avg_count = `PMAC_AVG4;
      3'h5:    pmac_avg_count = `PMAC_AVG5;
      3'h6:    pmac_avg_count = `PMAC_AVG6;
      default: pmac_avg_count = `PMAC_AVG7;
    endcase
  endfunction

  // Lowest enabled channel at or above the given index, or none
  function automatic pmac_ch_t pmac_next_ch(input logic [2:0] mask, input logic [1:0] from);
    pmac_next_ch = CH_NONE;
    for (int i = 2; i >= 0; i--) begin
      if (mask[i] && (i >= int'(from))) begin
        pmac_next_ch = pmac_ch_t'(i);
      end
    end
  endfunction

endpackage

// >>> core/pmac_top.sv
// Configuration registers and conversion sequencer of the power monitor converter
//
// Behaviour
// - Writing one to bit 15 resets all registers as power-on; bit reads zero
// - Device configuration bits 14, 5 and 3..0 always read as zero
// - Bits 13..6 delay the first conversion by code times 2 ms
// - Bit 4 picks shunt range: 0 wide 163.84 mV, 1 narrow 40.96 mV
// - Mode field bits 15..12, default Fh; codes 0h and 8h mean shutdown
// - Codes 1h..7h run one triggered pass over bus, shunt, temperature subsets
// - Codes 9h..Fh convert continuously over the coded channel subset
// - Bits 11..9 set bus conversion time, 50 to 4120 us, default 5h
// - Bits 8..6 set shunt conversion time with the same steps, default 5h
// - Bits 5..3 set temperature conversion time with same steps, default 5h
// - Bits 2..0 set averaging 1..1024; results update only after averaging
// - Register words move most significant byte first, then least significant
`include "pmac_map.svh"
`timescale 1ns/100ps
`default_nettype none

module pmac_top #(
  parameter int DLY_STEP_CYCLES  = `PMAC_DLY_STEP_MS * 1000 * `PMAC_CLK_MHZ,
  parameter int CONV_CYC_PER_US  = `PMAC_CLK_MHZ
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        xfer_start_i,
  input  wire logic        wr_valid_i,
  input  wire logic [7:0]  wr_byte_i,
  input  wire logic        rd_req_i,
  output var  logic        rd_valid_o,
  output var  logic [7:0]  rd_byte_o,
  output var  logic        shunt_range_o,
  output var  logic        shutdown_o,
  output var  logic        conv_busy_o,
  output var  logic [2:0]  conv_channel_o,
  output var  logic        sample_strobe_o,
  output var  logic [2:0]  result_update_o
);
  import pmac_pkg::*;

  // ========================================================================
  // Declarations
  pmac_wr_state_t  wr_state;
  pmac_seq_state_t state;
  pmac_ch_t        cur_ch;
  pmac_ch_t        next_ch;
  pmac_ch_t        first_ch;
  pmac_ch_t        go_ch;
  logic [1:0]      next_from;
  logic [7:0]      ptr;
  logic [7:0]      msb_hold;
  logic [15:0]     wr_word;
  logic            commit;
  logic            soft_rst;
  logic            restart;
  logic [7:0]      start_delay;
  logic            range_sel;
  logic [15:0]     conv_cfg;
  logic [15:0]     rd_word;
  logic [7:0]      rd_lsb_hold;
  logic            rd_phase;
  logic [2:0]      act_mask;
  logic            mode_cont;
  logic [10:0]     avg_cnt;
  logic [10:0]     samples;
  logic            last_sample;
  logic [2:0]      go_ct;
  logic [19:0]     go_cycles;

  // Named copy of the default word; a bare literal cannot be part-selected
  localparam logic [15:0] DEV_CFG_DEFAULT = `PMAC_DEV_CFG_RESET;

  pmac_ctl_if ctl_if ();

  // ========================================================================
  // Countdown helpers
  pmac_delay_timer #(
    .STEP_CYCLES (DLY_STEP_CYCLES)
  ) u_delay (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .ctl     (ctl_if.dly)
  );

  pmac_conv_timer u_conv (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .ctl     (ctl_if.cnv)
  );

  // One-hot view of a channel index
  function automatic logic [2:0] ch_onehot(input pmac_ch_t ch);
    ch_onehot = (ch == CH_NONE) ? 3'h0 : (3'h1 << ch);
  endfunction

  // ========================================================================
  // Byte stream framing: pointer, then high byte, then low byte
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_state <= W_PTR;
      ptr      <= `PMAC_PTR_DEV_CFG;
      msb_hold <= 8'h00;
    end else if (soft_rst) begin
      wr_state <= W_PTR;
      ptr      <= `PMAC_PTR_DEV_CFG;
      msb_hold <= 8'h00;
    end else if (xfer_start_i) begin
      wr_state <= W_PTR;
    end else if (wr_valid_i) begin
      case (wr_state)
        W_PTR: begin
          ptr      <= wr_byte_i;
          wr_state <= W_MSB;
        end
        W_MSB: begin
          msb_hold <= wr_byte_i;
          wr_state <= W_LSB;
        end
        W_LSB:   wr_state <= W_IGN;
        W_IGN:   wr_state <= W_IGN;
        default: wr_state <= W_PTR;
      endcase
    end
  end

  // Word completes on the low byte; extra bytes are dropped
  assign commit  = wr_valid_i && (wr_state == W_LSB) && !xfer_start_i && !soft_rst;
  assign wr_word = {msb_hold, wr_byte_i};

  // ========================================================================
  // Software reset pulse; the bit itself is never stored
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= commit && (ptr == `PMAC_PTR_DEV_CFG) && wr_word[`PMAC_DEV_RST_BIT];
    end
  end

  // Sequencer restart after reset, soft reset or a converter setting write
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      restart <= 1'b1;
    end else begin
      restart <= soft_rst || (commit && (ptr == `PMAC_PTR_CONV_CFG));
    end
  end

  // ========================================================================
  // Device configuration: startup delay and shunt range
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_delay <= DEV_CFG_DEFAULT[`PMAC_DLY_MSB:`PMAC_DLY_LSB];
      range_sel   <= DEV_CFG_DEFAULT[`PMAC_RANGE_BIT];
    end else if (soft_rst) begin
      start_delay <= DEV_CFG_DEFAULT[`PMAC_DLY_MSB:`PMAC_DLY_LSB];
      range_sel   <= DEV_CFG_DEFAULT[`PMAC_RANGE_BIT];
    end else if (commit && (ptr == `PMAC_PTR_DEV_CFG) && !wr_word[`PMAC_DEV_RST_BIT]) begin
      start_delay <= wr_word[`PMAC_DLY_MSB:`PMAC_DLY_LSB];
      range_sel   <= wr_word[`PMAC_RANGE_BIT];
    end
  end

  // Converter configuration: mode, conversion times, averaging
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conv_cfg <= `PMAC_CONV_CFG_RESET;
    end else if (soft_rst) begin
      conv_cfg <= `PMAC_CONV_CFG_RESET;
    end else if (commit && (ptr == `PMAC_PTR_CONV_CFG)) begin
      conv_cfg <= wr_word;
    end
  end

  // ========================================================================
  // Read word assembly; unused pointers read as zero
  always_comb begin
    rd_word = 16'h0000;
    if (ptr == `PMAC_PTR_DEV_CFG) begin
      rd_word[`PMAC_DLY_MSB:`PMAC_DLY_LSB] = start_delay;
      rd_word[`PMAC_RANGE_BIT]             = range_sel;
    end else if (ptr == `PMAC_PTR_CONV_CFG) begin
      rd_word = conv_cfg;
    end
  end

  // High byte first; low byte held so both halves come from one snapshot
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_phase    <= 1'b0;
      rd_lsb_hold <= 8'h00;
      rd_byte_o   <= 8'h00;
      rd_valid_o  <= 1'b0;
    end else begin
      rd_valid_o <= rd_req_i;
      if (xfer_start_i || soft_rst) begin
        rd_phase <= 1'b0;
      end else if (rd_req_i) begin
        if (!rd_phase) begin
          rd_byte_o   <= rd_word[15:8];
          rd_lsb_hold <= rd_word[7:0];
          rd_phase    <= 1'b1;
        end else begin
          rd_byte_o <= rd_lsb_hold;
          rd_phase  <= 1'b0;
        end
      end
    end
  end

  // ========================================================================
  // Mode decode: low three bits pick channels, top bit picks continuous
  assign act_mask  = conv_cfg[`PMAC_MODE_LSB+2:`PMAC_MODE_LSB];
  assign mode_cont = conv_cfg[`PMAC_MODE_LSB+`PMAC_MODE_CONT_BIT];
  assign avg_cnt   = pmac_avg_count(conv_cfg[`PMAC_AVG_MSB:`PMAC_AVG_LSB]);

  // Next channel in bus, shunt, temperature order; wrap only when continuous
  assign next_from   = (cur_ch == CH_NONE) ? 2'h0 : (cur_ch + 2'h1);
  assign next_ch     = pmac_next_ch(act_mask, next_from);
  assign first_ch    = pmac_next_ch(act_mask, 2'h0);
  assign go_ch       = (next_ch != CH_NONE) ? next_ch : (mode_cont ? first_ch : CH_NONE);
  assign last_sample = (samples == (avg_cnt - 11'h001));

  // Conversion time of the channel about to start
  always_comb begin
    case (go_ch)
      2'h0:    go_ct = conv_cfg[`PMAC_BUSCT_MSB:`PMAC_BUSCT_LSB];
      2'h1:    go_ct = conv_cfg[`PMAC_SHCT_MSB:`PMAC_SHCT_LSB];
      default: go_ct = conv_cfg[`PMAC_TMPCT_MSB:`PMAC_TMPCT_LSB];
    endcase
    go_cycles = 20'(pmac_conv_us(go_ct)) * 20'(CONV_CYC_PER_US);
  end

  // ========================================================================
  // Sequencer state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state   <= S_OFF;
      cur_ch  <= CH_NONE;
      samples <= 11'h000;
    end else if (restart) begin
      cur_ch  <= CH_NONE;
      samples <= 11'h000;
      state   <= (act_mask == 3'h0) ? S_OFF : S_DELAY;
    end else begin
      case (state)
        S_OFF: state <= S_OFF;
        S_DELAY: begin
          if (ctl_if.delay_done) begin
            state <= S_NEXT;
          end
        end
        S_CONV: begin
          if (ctl_if.conv_done) begin
            if (last_sample) begin
              samples <= 11'h000;
              state   <= S_NEXT;
            end else begin
              samples <= samples + 11'h001;
            end
          end
        end
        S_NEXT: begin
          cur_ch <= go_ch;
          state  <= (go_ch == CH_NONE) ? S_OFF : S_CONV;
        end
        default: state <= S_OFF;
      endcase
    end
  end

  // Timer requests; a restart also clears any countdown in flight
  assign ctl_if.clear      = soft_rst || restart;
  assign ctl_if.delay_code = start_delay;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl_if.delay_start <= 1'b0;
      ctl_if.conv_start  <= 1'b0;
      ctl_if.conv_cycles <= 20'h0_0001;
    end else begin
      ctl_if.delay_start <= restart && (act_mask != 3'h0);
      ctl_if.conv_start  <= 1'b0;
      if (!restart && (state == S_NEXT) && (go_ch != CH_NONE)) begin
        ctl_if.conv_start  <= 1'b1;
        ctl_if.conv_cycles <= go_cycles;
      end else if (!restart && (state == S_CONV) && ctl_if.conv_done && !last_sample) begin
        ctl_if.conv_start <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Registered status outputs
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shunt_range_o   <= 1'b0;
      shutdown_o      <= 1'b0;
      conv_busy_o     <= 1'b0;
      conv_channel_o  <= 3'h0;
      sample_strobe_o <= 1'b0;
      result_update_o <= 3'h0;
    end else begin
      shunt_range_o   <= range_sel;
      shutdown_o      <= (act_mask == 3'h0);
      conv_busy_o     <= (state == S_CONV);
      conv_channel_o  <= (state == S_CONV) ? ch_onehot(cur_ch) : 3'h0;
      sample_strobe_o <= (state == S_CONV) && ctl_if.conv_done && !restart;
      // Results publish only once the whole averaging run is in
      result_update_o <= ((state == S_CONV) && ctl_if.conv_done && last_sample && !restart)
                         ? ch_onehot(cur_ch) : 3'h0;
    end
  end

endmodule

`default_nettype wire

// >>> dv/pmac_checker.sv
// Port checker of the converter configuration block
`timescale 1ns/100ps
`default_nettype none

module pmac_checker (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        rd_req_i,
  input  wire logic        rd_valid_o,
  input  wire logic [7:0]  rd_byte_o,
  input  wire logic        shutdown_o,
  input  wire logic [2:0]  conv_channel_o,
  input  wire logic        sample_strobe_o,
  input  wire logic [2:0]  result_update_o
);
  // ==========================================================================
  // Read answers and sequencer relations, all in the one clock domain
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  rd_answer_a: assert property (rd_req_i |=> rd_valid_o)
    else $error("read byte not answered");
  rd_quiet_a: assert property (!rd_req_i |=> !rd_valid_o)
    else $error("read answer without request");
  rd_hold_a: assert property (!rd_valid_o |-> $stable(rd_byte_o))
    else $error("read byte changed without answer");
  shutdown_idle_a: assert property (shutdown_o [*2] |-> conv_channel_o == 3'h0)
    else $error("channel active in shutdown");
  chan_onehot_a: assert property ($onehot0(conv_channel_o))
    else $error("more than one channel active");
  // Shortest conversion is 50 cycles even at the smallest time scale
  strobe_gap_a: assert property (sample_strobe_o |=> !sample_strobe_o [*8])
    else $error("samples closer than shortest time");
  update_strobe_a: assert property (|result_update_o |-> sample_strobe_o)
    else $error("result update without sample");
  update_onehot_a: assert property ($onehot0(result_update_o))
    else $error("result update on several channels");
endmodule

bind pmac_top pmac_checker i_pmac_checker (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .rd_req_i(rd_req_i), .rd_valid_o(rd_valid_o),
  .rd_byte_o(rd_byte_o), .shutdown_o(shutdown_o), .conv_channel_o(conv_channel_o),
  .sample_strobe_o(sample_strobe_o), .result_update_o(result_update_o));

`default_nettype wire

// >>> dv/pmac_host.sv
// Host model moving register words over the byte port
`timescale 1ns/100ps
`default_nettype none

module pmac_host (
  input  wire logic        clk_i,
  output var  logic        xfer_start_o,
  output var  logic        wr_valid_o,
  output var  logic [7:0]  wr_byte_o,
  output var  logic        rd_req_o,
  input  wire logic        rd_valid_i,
  input  wire logic [7:0]  rd_byte_i
);
  // ==========================================================================
  // Idle levels
  initial begin
    xfer_start_o = 1'b0;
    wr_valid_o = 1'b0;
    wr_byte_o = 8'h00;
    rd_req_o = 1'b0;
  end

  task automatic step();
    @(posedge clk_i);
    #1;
  endtask

  // One byte per cycle; the start pulse drops with the first byte
  task automatic put(input logic [7:0] b);
    step();
    xfer_start_o = 1'b0;
    wr_valid_o = 1'b1;
    wr_byte_o = b;
  endtask

  // Released lane shows the inverse so a stale byte cannot pass as data
  task automatic open_frame(input logic [7:0] ptr);
    step();
    xfer_start_o = 1'b1;
    put(ptr);
  endtask

  task automatic write_reg(input logic [7:0] ptr, input logic [15:0] w);
    open_frame(ptr);
    put(w[15:8]);
    put(w[7:0]);
    step();
    wr_valid_o = 1'b0;
    wr_byte_o = ~wr_byte_o;
  endtask

  // Two back to back byte requests; a missing answer yields unknowns
  task automatic read_reg(input logic [7:0] ptr, output logic [15:0] w);
    open_frame(ptr);
    step();
    wr_valid_o = 1'b0;
    wr_byte_o = ~wr_byte_o;
    rd_req_o = 1'b1;
    step();
    w[15:8] = rd_valid_i ? rd_byte_i : 8'hxx;
    step();
    rd_req_o = 1'b0;
    w[7:0] = rd_valid_i ? rd_byte_i : 8'hxx;
  endtask
endmodule

`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench of the converter configuration block
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  localparam int STEP = 4;
  logic        clk_i, rst_b_i, xfer_start, wr_valid, rd_req, rd_valid;
  logic        shunt_range, shutdown, busy, strobe;
  logic [7:0]  wr_byte, rd_byte;
  logic [2:0]  chan, update, seen;
  logic        busy_seen;
  logic [15:0] w;
  int          fail_count = 0, total_checks = 0, cycles = 0;
  int          k, n, d0, d1;
  int          ct_us [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};

  pmac_top #(.DLY_STEP_CYCLES(STEP), .CONV_CYC_PER_US(1)) i_pmac_top (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .xfer_start_i(xfer_start), .wr_valid_i(wr_valid),
    .wr_byte_i(wr_byte), .rd_req_i(rd_req), .rd_valid_o(rd_valid), .rd_byte_o(rd_byte),
    .shunt_range_o(shunt_range), .shutdown_o(shutdown), .conv_busy_o(busy),
    .conv_channel_o(chan), .sample_strobe_o(strobe), .result_update_o(update));
  pmac_host i_pmac_host (
    .clk_i(clk_i), .xfer_start_o(xfer_start), .wr_valid_o(wr_valid), .wr_byte_o(wr_byte),
    .rd_req_o(rd_req), .rd_valid_i(rd_valid), .rd_byte_i(rd_byte));

  // ==========================================================================
  // Clock and cycle ceiling; the longest runs are the slow conversion times
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 95000) begin
      fail_count++;
      summarize();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic summarize();
    if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] v);
    i_pmac_host.write_reg(p, v);
  endtask
  task automatic rd(input logic [7:0] p, input logic [15:0] exp);
    i_pmac_host.read_reg(p, w);
    chk(w, exp);
  endtask
  task automatic wait_strobe();
    for (int i = 0; i < 9000 && strobe !== 1'b1; i++) step();
    if (strobe !== 1'b1) chk(16'(strobe), 16'h0001);
  endtask
  // Skips the first sample so a stale one from the old mode is not timed
  task automatic spacing(input logic [15:0] mw, output int d);
    wr(8'h01, mw);
    wait_strobe();
    step();
    wait_strobe();
    step();
    d = cycles;
    wait_strobe();
    d = cycles - d;
  endtask
  task automatic latency(input logic [15:0] dev, output int d);
    wr(8'h00, dev);
    wr(8'h01, 16'h0000);
    repeat (4) step();
    wr(8'h01, 16'h9000);
    for (d = 0; d < 3000 && chan === 3'h0; d++) step();
  endtask

  // ==========================================================================
  // Test sequence
  initial begin
    rst_b_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    rd(8'h00, 16'h0000);
    rd(8'h01, 16'hFB68);
    rd(8'h05, 16'h0000);
    chk(16'(shunt_range), 16'h0000);
    wr(8'h00, 16'h7FFF);
    rd(8'h00, 16'h3FD0);
    chk(16'(shunt_range), 16'h0001);
    wr(8'h01, 16'h1234);
    rd(8'h01, 16'h1234);
    wr(8'h00, 16'h8000);
    rd(8'h00, 16'h0000);
    rd(8'h01, 16'hFB68);
    chk(16'(shunt_range), 16'h0000);
    // Every mode code: channel set seen over one window
    for (k = 0; k < 16; k++) begin
      wr(8'h01, {k[3:0], 12'h000});
      repeat (4) step();
      seen = 3'h0;
      busy_seen = 1'b0;
      repeat (400) begin
        step();
        seen = seen | chan;
        busy_seen = busy_seen | busy;
      end
      chk(16'(seen), 16'(k[2:0]));
      chk(16'(busy_seen), 16'(k[2:0] != 3'h0));
      chk(16'(shutdown), 16'(k[2:0] == 3'h0));
      if (k < 8) chk(16'(busy), 16'h0000);
    end
    latency(16'h3FC0, d1);
    latency(16'h0000, d0);
    chk(16'(d1 - d0 >= 255 * STEP && d1 - d0 <= 255 * STEP + 1), 16'h0001);
    spacing(16'h9000, d0);
    for (k = 1; k < 8; k++) begin
      spacing(16'h9000 | 16'(k << 9), d1);
      chk(16'(d1 - d0), 16'(ct_us[k] - ct_us[0]));
    end
    spacing(16'hA180, d1);
    chk(16'(d1 - d0), 16'(ct_us[6] - ct_us[0]));
    spacing(16'hC030, d1);
    chk(16'(d1 - d0), 16'(ct_us[6] - ct_us[0]));
    // Four samples per bus result when averaging code is one
    wr(8'h01, 16'h9001);
    repeat (3) begin
      for (k = 0; k < 3000 && update === 3'h0; k++) step();
      step();
    end
    n = 0;
    for (k = 0; k < 3000 && (n == 0 || update === 3'h0); k++) begin
      step();
      n += int'(strobe === 1'b1);
    end
    chk(16'(n), 16'h0004);
    chk(16'(update), 16'h0001);
    summarize();
  end
endmodule

`default_nettype wire
